// [logic/dclk_ff.sv]
// one logic flip-flop with clock-qualified 1-set and 0-set inputs
`timescale 1ns/1ps
module dclk_ff (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // machine clock true-to-false event
  input wire logic i_fall,
  // set inputs, already qualified by the clock true level
  input wire logic i_set1,
  input wire logic i_set0,
  // state
  output logic o_q
);
  import dclk_pkg::*;

  // set inputs are sampled only at the falling event, so a newly
  // changing output cannot feed back into the same update
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_q <= FF_RST;
    end else if (i_fall) begin
      if (i_set1 && !o_q) begin
        o_q <= 1'b1;
      end else if (i_set0 && o_q) begin
        o_q <= 1'b0;
      end
    end
  end

  hold_no_fall_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !i_fall |=> $stable(o_q))
    else $error("flip-flop changed without a clock fall");

  flip_on_set_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_fall && (i_set1 != i_set0) |=> o_q == $past(i_set1))
    else $error("flip-flop missed its set input");

  both_sets_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !(i_set1 && i_set0))
    else $error("both set inputs active together");
endmodule : dclk_ff

// [logic/dclk_pkg.sv]
// constants and carrier types for the disk-derived machine clock block
// Function
// - one machine clock per reference cycle
// - fixed false interval, true for the rest
// - state changes only on true-to-false edge
// - only rising reference edges fire the one-shot
// - strobe to read amps, inverted copy out
// - tester requests, device delivers counted clock pulses
// - tester pulses replace reference, giving spaced pairs
// - and gate true only if all true
// - shared product term computed once, fed onward
// - set equals or of terms, clock qualified
// - next state uses only pre-update values
// - word keeps 37 digits on track, 4 here
// - flip-flop flips only on opposite set
package dclk_pkg;
  // clock rate and printed timing figures
  localparam int CLK_NS = 10;
  localparam int REF_RATE_KC = 153;
  localparam int FALSE_NS = 1750;
  localparam int TRUE_NS = 4620;
  // a least time rounds up to whole cycles
  localparam int FALSE_CYC = (FALSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRUE_CYC = TRUE_NS / CLK_NS;
  localparam int CNT_W = 9;
  // register split between track and flip-flops
  localparam int TRACK_DIGITS = 37;
  localparam int FF_DIGITS = 4;
  localparam int WORD_DIGITS = TRACK_DIGITS + FF_DIGITS;
  // reset values
  localparam logic FF_RST = 1'h0;
  localparam logic CLK_RST = 1'h1;

  // tester and reference pins, all asynchronous
  typedef struct packed {
    logic ref_sq;
    logic jit_pulse;
    logic single_req;
  } dclk_pins_t;

  // outputs of the clock chain
  typedef struct packed {
    logic clk;
    logic clk_n;
    logic strobe;
  } dclk_clk_t;

  // one-shot phase
  typedef enum logic [0:0] {
    ST_TRUE = 1'b0,
    ST_FALSE = 1'b1
  } dclk_phase_t;
endpackage : dclk_pkg

// [logic/dclk_top.sv]
// machine clock from the reference track, test modes and gated set logic
`timescale 1ns/1ps
module dclk_top #(
  parameter int JIT_W = 8,
  parameter int SGL_W = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // reference and tester pins
  input wire dclk_pkg::dclk_pins_t i_pins,
  input wire logic i_jitter_mode,
  input wire logic [JIT_W-1:0] i_jitter_space,
  input wire logic i_single_mode,
  input wire logic [SGL_W-1:0] i_single_count,
  // gate inputs from other flip-flops
  input wire logic [2:0] i_term_a,
  input wire logic [2:0] i_term_b,
  input wire logic [5:0] i_common,
  input wire logic i_acc_bit,
  input wire logic i_rem_bit,
  input wire logic i_acc_qual,
  input wire logic i_rem_qual,
  input wire logic i_track_in,
  // clock chain outputs
  output dclk_pkg::dclk_clk_t o_clk,
  output logic o_fall,
  // flip-flop states
  output logic o_x,
  output logic o_acc,
  output logic o_rem,
  output logic [dclk_pkg::FF_DIGITS-1:0] o_digits
);
  import dclk_pkg::*;

  initial begin
    if (JIT_W < 1 || JIT_W > 16 || SGL_W < 1 || SGL_W > 16) begin
      $error("dclk_top: JIT_W and SGL_W must lie in 1..16");
    end
  end

  // and gate: any false input forces a false output
  function automatic logic and3(input logic [2:0] v);
    and3 = v[0] & v[1] & v[2];
  endfunction : and3

  // three-stage pin synchroniser; s1 is read by s2 only
  dclk_pins_t s1;
  dclk_pins_t s2;
  dclk_pins_t s3;
  dclk_pins_t pin_f;
  dclk_pins_t pin_d;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_f <= '0;
      pin_d <= '0;
    end else begin
      pin_f <= (s2 ^ s3) == '0 ? s2 : pin_f;
      pin_d <= pin_f;
    end
  end

  logic ref_rise;
  logic jit_rise;
  logic req_rise;
  assign ref_rise = pin_f.ref_sq & ~pin_d.ref_sq;
  assign jit_rise = pin_f.jit_pulse & ~pin_d.jit_pulse;
  assign req_rise = pin_f.single_req & ~pin_d.single_req;

  dclk_phase_t phase;
  logic [CNT_W-1:0] false_cnt;
  logic [SGL_W-1:0] pend;
  logic [JIT_W:0] jit_cnt;
  logic jit_second;
  logic trig;
  logic fire;
  logic clk_true;

  // pick the trigger source; in jitter mode the tester replaces the track
  always_comb begin
    trig = 1'b0;
    if (i_jitter_mode) begin
      trig = jit_rise | jit_second;
    end else if (i_single_mode) begin
      trig = ref_rise && (pend != '0);
    end else begin
      trig = ref_rise;
    end
  end
  assign clk_true = (phase == ST_TRUE);
  // edges that land inside the false interval are ignored, not queued
  assign fire = trig && clk_true;

  // one-shot: fixed false width, true until the next reference edge
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      phase <= ST_TRUE;
      false_cnt <= '0;
    end else begin
      unique case (phase)
        ST_TRUE: begin
          if (fire) begin
            phase <= ST_FALSE;
            false_cnt <= CNT_W'(1);
          end
        end
        ST_FALSE: begin
          if (false_cnt == CNT_W'(FALSE_CYC)) begin
            phase <= ST_TRUE;
            false_cnt <= '0;
          end else begin
            false_cnt <= false_cnt + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // single-cycle budget: loaded by a tester request, spent per pulse
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_single_mode) begin
      pend <= '0;
    end else if (req_rise) begin
      pend <= (i_single_count == '0) ? SGL_W'(1) : i_single_count;
    end else if (fire && pend != '0) begin
      pend <= pend - SGL_W'(1);
    end
  end

  // second pulse of a pair: spacing counted from the end of the first
  // false interval, so a short spacing still yields two distinct pulses
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_jitter_mode) begin
      jit_cnt <= '0;
      jit_second <= 1'b0;
    end else if (fire && jit_rise) begin
      jit_cnt <= {1'b0, i_jitter_space} + (JIT_W + 1)'(1);
      jit_second <= 1'b0;
    end else if (clk_true && jit_cnt != '0) begin
      jit_cnt <= jit_cnt - (JIT_W + 1)'(1);
      jit_second <= (jit_cnt == (JIT_W + 1)'(1));
    end else begin
      jit_second <= 1'b0;
    end
  end

  // registered clock chain; strobe and driver copy are the shaped pulse
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_clk <= '{clk: CLK_RST, clk_n: ~CLK_RST, strobe: ~CLK_RST};
      o_fall <= 1'b0;
    end else begin
      o_clk.clk <= ~(fire | (phase == ST_FALSE &&
                   false_cnt != CNT_W'(FALSE_CYC)));
      o_clk.clk_n <= fire | (phase == ST_FALSE &&
                     false_cnt != CNT_W'(FALSE_CYC));
      o_clk.strobe <= fire | (phase == ST_FALSE &&
                      false_cnt != CNT_W'(FALSE_CYC));
      o_fall <= fire;
    end
  end

  // and-or set logic, clock qualified; inactive when no term is true
  logic x_set1;
  logic shared_term;
  logic acc_set1;
  logic acc_set0;
  logic rem_set1;
  logic rem_set0;
  assign x_set1 = (and3(i_term_a) | and3(i_term_b)) & clk_true;
  // the common product is formed once and feeds every secondary gate
  assign shared_term = and3(i_common[2:0]) & and3(i_common[5:3]);
  assign acc_set1 = i_acc_bit & shared_term & i_acc_qual & clk_true;
  assign acc_set0 = ~i_acc_bit & shared_term & i_acc_qual & clk_true;
  assign rem_set1 = i_rem_bit & shared_term & i_rem_qual & clk_true;
  assign rem_set0 = ~i_rem_bit & shared_term & i_rem_qual & clk_true;

  dclk_ff u_x (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_fall(fire),
    .i_set1(x_set1),
    .i_set0(1'b0),
    .o_q(o_x)
  );
  dclk_ff u_acc (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_fall(fire),
    .i_set1(acc_set1),
    .i_set0(acc_set0),
    .o_q(o_acc)
  );
  dclk_ff u_rem (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_fall(fire),
    .i_set1(rem_set1),
    .i_set0(rem_set0),
    .o_q(o_rem)
  );

  // four word digits held here; the track supplies the incoming digit
  logic [FF_DIGITS:0] chain;
  assign chain = {i_track_in, o_digits};
  for (genvar g = 0; g < FF_DIGITS; g++) begin : g_dig
    dclk_ff u_d (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_fall(fire),
      .i_set1(chain[g+1] & clk_true),
      .i_set0(~chain[g+1] & clk_true),
      .o_q(o_digits[g])
    );
  end

  // helper: length of the current false run
  logic [CNT_W-1:0] false_run;
  always_ff @(posedge i_clk) begin
    if (!i_resetn || o_clk.clk) begin
      false_run <= '0;
    end else begin
      false_run <= false_run + CNT_W'(1);
    end
  end

  sequence clk_falls;
    $fell(o_clk.clk);
  endsequence
  sequence clk_rises;
    $rose(o_clk.clk);
  endsequence

  false_width_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    clk_rises |-> $past(false_run) == CNT_W'(FALSE_CYC - 1))
    else $error("false interval has wrong width");

  fall_cause_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    clk_falls |-> $past(trig) && $past(clk_true))
    else $error("clock fell without a trigger");

  strobe_copy_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_clk.strobe == ~o_clk.clk && o_clk.clk_n == ~o_clk.clk)
    else $error("strobe or inverted clock out of step");

  single_budget_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    fire && i_single_mode && !i_jitter_mode |-> pend != '0)
    else $error("single-cycle pulse without a request");

  jitter_pair_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    fire && jit_rise && i_jitter_mode && i_jitter_space == '0 |=>
      (i_jitter_mode [*1] ##177 $fell(o_clk.clk)) or !i_jitter_mode)
    else $error("jitter pair second pulse missing");

  and_or_gate_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(o_x) |-> $past(and3(i_term_a) | and3(i_term_b)) && $past(fire))
    else $error("x set without a true product term");

  shared_gate_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    acc_set1 || acc_set0 || rem_set1 || rem_set0 |-> &i_common)
    else $error("secondary gate active without shared term");

  digit_shift_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    fire |=> o_digits[FF_DIGITS-1] == $past(i_track_in) &&
      o_digits[FF_DIGITS-2:0] == $past(o_digits[FF_DIGITS-1:1]))
    else $error("word digits did not shift at the fall");
endmodule : dclk_top

// [testbench/dclk_src.sv]
// reference track and tester pin model for the machine clock block
`timescale 1ns/1ps
module dclk_src (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // control from the bench
  input wire logic i_run,
  input wire logic [9:0] i_period,
  input wire logic i_jit,
  input wire logic i_sgl,
  // pins of the block
  output dclk_pkg::dclk_pins_t o_pins
);
  import dclk_pkg::*;
  logic [9:0] ph;
  // squared reference, one rise per period, low while stopped
  always @(posedge i_clk) begin
    if (!i_resetn || !i_run || ph >= i_period - 10'h1) begin
      ph <= 10'h0;
    end else begin
      ph <= ph + 10'h1;
    end
  end
  // tester levels pass through; the bench holds them past the pin filter
  always @(posedge i_clk) begin
    o_pins.ref_sq <= i_run && (ph < (i_period >> 1));
    o_pins.jit_pulse <= i_jit;
    o_pins.single_req <= i_sgl;
  end
endmodule : dclk_src

// [testbench/test_dclk_top.sv]
// self-checking bench for the machine clock block
`timescale 1ns/1ps
module test_dclk_top;
  import dclk_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, run = 1'b0, jit = 1'b0, sgl = 1'b0;
  logic jmode = 1'b0, smode = 1'b0, acc_bit = 1'b0, rem_bit = 1'b0;
  logic acc_qual = 1'b0, rem_qual = 1'b0, track = 1'b0;
  logic [7:0] jspace = 8'h00;
  logic [3:0] scount = 4'h0, exp_dig = 4'h0;
  logic [2:0] ta = 3'h0, tb = 3'h0;
  logic [5:0] common = 6'h00;
  logic [9:0] period = 10'h28e;
  dclk_pins_t pins;
  dclk_clk_t clk_o;
  logic fall, x, acc, rem;
  logic [3:0] digits;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  dclk_src u_src (.i_clk(i_clk), .i_resetn(i_resetn), .i_run(run),
    .i_period(period), .i_jit(jit), .i_sgl(sgl), .o_pins(pins));
  dclk_top #(.JIT_W(8), .SGL_W(4)) DUT (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_pins(pins), .i_jitter_mode(jmode), .i_jitter_space(jspace),
    .i_single_mode(smode), .i_single_count(scount), .i_term_a(ta),
    .i_term_b(tb), .i_common(common), .i_acc_bit(acc_bit),
    .i_rem_bit(rem_bit), .i_acc_qual(acc_qual), .i_rem_qual(rem_qual),
    .i_track_in(track), .o_clk(clk_o), .o_fall(fall), .o_x(x),
    .o_acc(acc), .o_rem(rem), .o_digits(digits));
  // 100 MHz clock and a hang guard well above the planned run
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // inputs move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // outputs are sampled on the falling edge, where they are settled
  task automatic wait_fall(output int t);
    int n;
    n = 0;
    @(negedge i_clk);
    while (fall !== 1'b1 && n < 2000) begin
      n++;
      @(negedge i_clk);
    end
    t = cyc;
  endtask : wait_fall
  task automatic count_falls(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(negedge i_clk);
      if (fall === 1'b1) n++;
    end
  endtask : count_falls
  task automatic t_clock();
    int t0, t1, n;
    run = 1'b1;
    wait_fall(t0);
    check({clk_o.clk, clk_o.clk_n, clk_o.strobe}, 3'h3);
    n = 0;
    while (clk_o.clk === 1'b0 && n < 400) begin
      n++;
      @(negedge i_clk);
    end
    check(n, FALSE_CYC);
    wait_fall(t1);
    check(t1 - t0, period);
  endtask : t_clock
  // one clock cycle of gate terms; the acc and rem sets share the common term and can act in the same step
  task automatic step(input logic [2:0] a, input logic [2:0] b,
      input logic [5:0] com, input logic [3:0] bits, input logic [2:0] e);
    logic [2:0] was;
    int t;
    tick(1);
    was = {x, acc, rem};
    ta = a;
    tb = b;
    common = com;
    {acc_bit, acc_qual, rem_bit, rem_qual} = bits;
    track = a[0];
    exp_dig = {a[0], exp_dig[3:1]};
    tick(2);
    check({x, acc, rem}, was);
    wait_fall(t);
    check({x, acc, rem}, e);
    check(digits, exp_dig);
  endtask : step
  task automatic t_gates();
    step(3'h6, 3'h3, 6'h3f, 4'hd, 3'h2);
    step(3'h7, 3'h0, 6'h3e, 4'h7, 3'h6);
    step(3'h0, 3'h7, 6'h3f, 4'h7, 3'h5);
    step(3'h1, 3'h0, 6'h3f, 4'hc, 3'h7);
  endtask : t_gates
  task automatic request(input logic [3:0] c, input int exp);
    int n;
    tick(1);
    scount = c;
    sgl = 1'b1;
    tick(8);
    sgl = 1'b0;
    count_falls(2000, n);
    check(n, exp);
  endtask : request
  task automatic t_single();
    int n;
    tick(1);
    smode = 1'b1;
    count_falls(1400, n);
    check(n, 0);
    request(4'h2, 2);
    request(4'h0, 1);
    tick(1);
    smode = 1'b0;
  endtask : t_single
  task automatic t_jitter(input logic [7:0] s);
    int t0, t1, n;
    tick(1);
    run = 1'b0;
    jmode = 1'b1;
    jspace = s;
    tick(300);
    // pulse held high so the first fall lands inside wait_fall
    jit = 1'b1;
    wait_fall(t0);
    wait_fall(t1);
    check(t1 - t0, FALSE_CYC + s + 2);
    count_falls(800, n);
    check(n, 0);
    tick(1);
    jit = 1'b0;
  endtask : t_jitter
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // reset for 16 cycles, then each scenario in turn
  initial begin
    tick(16);
    i_resetn = 1'b1;
    t_clock();
    t_gates();
    t_single();
    t_jitter(8'h00);
    t_jitter(8'h05);
    t_jitter(8'hff);
    print_verdict();
  end
endmodule : test_dclk_top
